// ===== core/rfhp_consts.vh
`ifndef RFHP_CONSTS_VH
`define RFHP_CONSTS_VH

// =====================================================================
// frame layout
`define RFHP_FRAME_BITS      5'd16
`define RFHP_ADDR_BITS       7
`define RFHP_DATA_BITS       8
`define RFHP_DIR_POS         5'd7
`define RFHP_LAST_POS        5'd15
`define RFHP_REG_COUNT       128
`define RFHP_CNT_ZERO        5'd0
`define RFHP_CNT_ONE         5'd1
`define RFHP_BYTE_ZERO       8'h00

// =====================================================================
// modulator configuration register and data formats
`define RFHP_MODCFG_ADDR     7'h03
`define RFHP_FMT_LO          0
`define RFHP_FMT_HI          1
`define RFHP_FMT_NRZ         2'h1
`define RFHP_LOCKSEL_POS     2

// =====================================================================
// timing
`define RFHP_CLK_NS          4
`define RFHP_SEL_HIGH_NS     50
`define RFHP_SEL_HIGH_CYC    ((`RFHP_SEL_HIGH_NS + `RFHP_CLK_NS - 1) / `RFHP_CLK_NS)
`define RFHP_HALF_BIT_CYC    16'd1000
`define RFHP_DIV_ZERO        16'h0000
`define RFHP_DIV_ONE         16'h0001

`endif

// ===== core/rfhp_sync2.v
`timescale 1ns/1ps
// =====================================================================
// two flip-flop level synchroniser
module rfhp_sync2 #(
    parameter RST_VAL = 1'b0
) (
    input  wire clk,     // core clock
    input  wire arst_n,  // async reset
    input  wire ce,      // clock enable
    input  wire d,       // async level
    output reg  q        // synchronised level
);
    reg meta;

    // first stage is read only by the second
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ===== core/rfhp_bitclk.v
`timescale 1ns/1ps
`include "rfhp_consts.vh"
// =====================================================================
// free running bit clock divider with gating
module rfhp_bitclk (
    input  wire        clk,       // core clock
    input  wire        arst_n,    // async reset
    input  wire        ce,        // clock enable
    input  wire        run,       // clock allowed to toggle
    input  wire [15:0] half_cyc,  // half period in core cycles
    output reg         bclk,      // bit clock level
    output reg         rise       // pulse: bit clock has just risen
);
    reg [15:0] cnt;

    // stopped clock parks low so the first edge after gating is a rise
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt  <= `RFHP_DIV_ZERO;
            bclk <= 1'b0;
            rise <= 1'b0;
        end else if (ce) begin
            rise <= 1'b0;
            if (!run) begin
                cnt  <= `RFHP_DIV_ZERO;
                bclk <= 1'b0;
            end else if (cnt >= half_cyc - `RFHP_DIV_ONE) begin
                cnt  <= `RFHP_DIV_ZERO;
                bclk <= ~bclk;
                rise <= ~bclk;
            end else begin
                cnt <= cnt + `RFHP_DIV_ONE;
            end
        end
    end
endmodule

// ===== core/rfhp_port.v
`timescale 1ns/1ps
`include "rfhp_consts.vh"
// Operation
// - 8-bit registers chosen by 7-bit address
// - frame: 7 address, direction, 8 data
// - address sent MSB first
// - direction high writes, low reads
// - sample serial input on clock rise
// - write register after final payload bit
// - power-down keeps register contents
// - writes accepted in any order
// - read frames return addressed register
// - read data changes on clock fall
// - pins inputs while select high
// - serial output drives only read data
// - lock output low when locked (with lock_sel set it shows carrier sense instead)
// - 2-bit field selects data format
// - NRZ transmit samples on clock rise
// - NRZ receive drives clock and data
// - bit clock runs continuously unless gated
module rfhp_port (
    input  wire clk,                    // 250 MHz core clock
    input  wire arst_n,                 // async reset, active low
    input  wire ce,                     // clock enable
    input  wire cfg_sel_n,              // frame select pin, active low
    input  wire cfg_sclk,               // serial clock pin
    input  wire cfg_serial_in,          // serial data in pin
    output reg  cfg_serial_out,         // serial read data
    output reg  cfg_serial_out_oe_n,    // low while serial out drives
    input  wire power_down,             // programmed power-down request
    input  wire synth_locked,           // synthesizer lock from analog
    input  wire carrier_sense,          // carrier sense from demodulator
    input  wire tx_mode,                // high transmit, low receive
    input  wire rx_bit,                 // recovered demodulator bit
    output reg  tx_bit,                 // bit handed to modulator
    output reg  tx_bit_valid,           // pulse: tx_bit updated
    output reg  radio_bit_clock,        // data clock to host
    input  wire radio_data_line_in,     // data pin level
    output reg  radio_data_line_out,    // data pin drive value
    output reg  radio_data_line_oe_n,   // low while data pin driven
    output reg  lock_status_n,          // lock / status, active low
    output reg  [1:0] data_format       // current format field
);
    // =================================================================
    // pin synchronisers
    wire sel_n_s;
    wire sclk_s;
    wire sdi_s;
    wire dio_s;

    rfhp_sync2 #(.RST_VAL(1'b1)) u_sel (.clk(clk), .arst_n(arst_n), .ce(ce), .d(cfg_sel_n), .q(sel_n_s));
    rfhp_sync2 #(.RST_VAL(1'b0)) u_sck (.clk(clk), .arst_n(arst_n), .ce(ce), .d(cfg_sclk), .q(sclk_s));
    rfhp_sync2 #(.RST_VAL(1'b0)) u_sdi (.clk(clk), .arst_n(arst_n), .ce(ce), .d(cfg_serial_in), .q(sdi_s));
    rfhp_sync2 #(.RST_VAL(1'b0)) u_dio (.clk(clk), .arst_n(arst_n), .ce(ce), .d(radio_data_line_in), .q(dio_s));

    // =================================================================
    // edge detection on synchronised serial clock
    reg  sclk_d;
    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_d <= 1'b0;
        end else if (ce) begin
            sclk_d <= sclk_s;
        end
    end

    // =================================================================
    // configuration storage
    // 8-bit registers
    // no clear on power-down; reset (supply loss) clears only the modcfg shadow, not the array
    reg [`RFHP_DATA_BITS-1:0] cfg_mem [0:`RFHP_REG_COUNT-1];
    reg [`RFHP_DATA_BITS-1:0] modcfg;   // shadow of the modulator config register

    // =================================================================
    // frame receiver
    reg [4:0]                 bit_cnt;
    reg [`RFHP_ADDR_BITS-1:0] addr;
    reg                       dir_wr;
    reg [`RFHP_DATA_BITS-1:0] shift;
    reg [`RFHP_DATA_BITS-1:0] rd_data;
    reg                       read_act;
    wire                      sel_act = ~sel_n_s;

    function is_data_bit;
        input [4:0] n;
        begin
            is_data_bit = (n > `RFHP_DIR_POS) && (n <= `RFHP_LAST_POS);
        end
    endfunction

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt  <= `RFHP_CNT_ZERO;
            addr     <= {`RFHP_ADDR_BITS{1'b0}};
            dir_wr   <= 1'b0;
            shift    <= `RFHP_BYTE_ZERO;
            read_act <= 1'b0;
            modcfg   <= `RFHP_BYTE_ZERO;
        end else if (ce) begin
            if (!sel_act) begin
                bit_cnt  <= `RFHP_CNT_ZERO;
                read_act <= 1'b0;
            end else if (sclk_rise) begin
                bit_cnt <= bit_cnt + `RFHP_CNT_ONE;
                if (bit_cnt < `RFHP_DIR_POS) begin
                    addr <= {addr[`RFHP_ADDR_BITS-2:0], sdi_s};
                end else if (bit_cnt == `RFHP_DIR_POS) begin
                    dir_wr   <= sdi_s;
                    read_act <= ~sdi_s;
                end else if (is_data_bit(bit_cnt)) begin
                    shift <= {shift[`RFHP_DATA_BITS-2:0], sdi_s};
                    if (bit_cnt == `RFHP_LAST_POS && dir_wr) begin
                        if (addr == `RFHP_MODCFG_ADDR) begin
                            modcfg <= {shift[`RFHP_DATA_BITS-2:0], sdi_s};
                        end
                    end
                end
            end
        end
    end

    // memory has no reset so it maps onto a plain array
    always @(posedge clk) begin
        if (ce && sel_act && sclk_rise && dir_wr && bit_cnt == `RFHP_LAST_POS) begin
            cfg_mem[addr] <= {shift[`RFHP_DATA_BITS-2:0], sdi_s};
        end
    end

    // =================================================================
    // read-back shifter
    // every address readable, modcfg from its shadow
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data             <= `RFHP_BYTE_ZERO;
            cfg_serial_out      <= 1'b0;
            cfg_serial_out_oe_n <= 1'b1;
        end else if (ce) begin
            if (!sel_act || !read_act) begin
                cfg_serial_out_oe_n <= 1'b1;
                cfg_serial_out      <= 1'b0;
            end else if (sclk_fall) begin
                if (bit_cnt == `RFHP_DIR_POS + `RFHP_CNT_ONE) begin
                    cfg_serial_out_oe_n <= 1'b0;
                    cfg_serial_out      <= (addr == `RFHP_MODCFG_ADDR) ? modcfg[`RFHP_DATA_BITS-1]
                                                                      : cfg_mem[addr][`RFHP_DATA_BITS-1];
                    rd_data             <= (addr == `RFHP_MODCFG_ADDR) ? {modcfg[`RFHP_DATA_BITS-2:0], 1'b0}
                                                                      : {cfg_mem[addr][`RFHP_DATA_BITS-2:0], 1'b0};
                end else if (is_data_bit(bit_cnt)) begin
                    cfg_serial_out <= rd_data[`RFHP_DATA_BITS-1];
                    rd_data        <= {rd_data[`RFHP_DATA_BITS-2:0], 1'b0};
                end else begin
                    cfg_serial_out_oe_n <= 1'b1;
                end
            end
        end
    end

    // =================================================================
    // data format and bit clock
    // format field
    wire [1:0] fmt      = modcfg[`RFHP_FMT_HI:`RFHP_FMT_LO];
    wire       sync_nrz = (fmt == `RFHP_FMT_NRZ);
    wire       lock_sel = modcfg[`RFHP_LOCKSEL_POS];
    wire       bclk;
    wire       brise;

    // continuous clock in sync mode, gated by lock and by power-down
    rfhp_bitclk u_bclk (
        .clk      (clk),
        .arst_n   (arst_n),
        .ce       (ce),
        .run      (sync_nrz & ~power_down & synth_locked),
        .half_cyc (`RFHP_HALF_BIT_CYC),
        .bclk     (bclk),
        .rise     (brise)
    );

    // =================================================================
    // synchronous NRZ data path
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            radio_bit_clock      <= 1'b0;
            radio_data_line_out  <= 1'b0;
            radio_data_line_oe_n <= 1'b1;
            tx_bit               <= 1'b0;
            tx_bit_valid         <= 1'b0;
            lock_status_n        <= 1'b1;
            data_format          <= 2'h0;
        end else if (ce) begin
            radio_bit_clock <= bclk;
            data_format     <= fmt;
            tx_bit_valid    <= 1'b0;
            // low when locked, or carrier sense when selected
            lock_status_n   <= lock_sel ? ~carrier_sense : ~synth_locked;
            if (tx_mode) begin
                radio_data_line_oe_n <= 1'b1;
                if (brise) begin
                    // sample host data at clock rise, no coding
                    tx_bit       <= dio_s;
                    tx_bit_valid <= 1'b1;
                end
            end else begin
                // data moves on the clock fall so it stands still at the host's rise
                radio_data_line_oe_n <= ~sync_nrz;
                if (radio_bit_clock && !bclk) begin
                    radio_data_line_out <= rx_bit;
                end
            end
        end
    end
endmodule

// ===== verification/rfhp_port_asserts.sv
`timescale 1ns/1ps
// ==================================================
// port level checks
module rfhp_port_asserts (
    input wire       clk,                  // core clock
    input wire       arst_n,               // async reset
    input wire       cfg_sel_n,            // select
    input wire       cfg_sclk,             // serial clock
    input wire       cfg_serial_out,       // read data
    input wire       cfg_serial_out_oe_n,  // read enable
    input wire       power_down,           // power-down
    input wire       synth_locked,         // lock in
    input wire       carrier_sense,        // carrier in
    input wire       tx_mode,              // transmit
    input wire       tx_bit_valid,         // tx strobe
    input wire       radio_bit_clock,      // bit clock
    input wire       radio_data_line_oe_n, // data enable
    input wire       lock_status_n,        // lock pin
    input wire [1:0] data_format           // format field
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // bit clock may run only in this state
    wire ok = (data_format == 2'h1) && synth_locked && !power_down;
    // half period counter; a delay range of a thousand cycles unrolls too slowly
    logic [10:0] half_cnt;
    logic        half_clean;
    logic        bclk_d;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            half_cnt   <= 11'h000;
            half_clean <= 1'b0;
            bclk_d     <= 1'b0;
        end else begin
            bclk_d <= radio_bit_clock;
            if (radio_bit_clock != bclk_d) begin
                // a half measured from a rise, only while the clock may run
                half_cnt   <= 11'h001;
                half_clean <= radio_bit_clock && ok;
            end else begin
                if (half_cnt != 11'h7ff) begin
                    half_cnt <= half_cnt + 11'h001;
                end
                half_clean <= half_clean && ok;
            end
        end
    end
    sequence s_half_start;
        $fell(radio_bit_clock) && half_clean;
    endsequence
    sequence s_lock_steady;
        (synth_locked == carrier_sense) ##1 (synth_locked == carrier_sense) && $stable(synth_locked);
    endsequence
    a_out_idle: assert property (cfg_sel_n [*6] |-> cfg_serial_out_oe_n)
        else $error("serial out driven while deselected");
    a_out_fall: assert property (!cfg_serial_out_oe_n && $changed(cfg_serial_out) |-> !cfg_sclk)
        else $error("read data moved while serial clock high");
    a_lock_follow: assert property (s_lock_steady |-> lock_status_n == !synth_locked)
        else $error("lock pin wrong");
    a_half_len: assert property (s_half_start |-> half_cnt == 11'd1000)
        else $error("bit clock half period wrong");
    a_park_unlock: assert property (!synth_locked [*8] |-> !radio_bit_clock)
        else $error("bit clock runs unlocked");
    a_park_pdown: assert property (power_down [*8] |-> !radio_bit_clock)
        else $error("bit clock runs in power-down");
    a_fmt_idle: assert property ((data_format != 2'h1) [*8] |-> !radio_bit_clock && radio_data_line_oe_n)
        else $error("data port active outside sync format");
    a_tx_input: assert property (tx_mode [*4] |-> radio_data_line_oe_n)
        else $error("data pin driven in transmit");
    a_tx_once: assert property (tx_bit_valid |=> !tx_bit_valid [*8])
        else $error("tx strobe repeated");
endmodule
bind rfhp_port rfhp_port_asserts u_chk (
    .clk, .arst_n, .cfg_sel_n, .cfg_sclk, .cfg_serial_out, .cfg_serial_out_oe_n, .power_down, .synth_locked,
    .carrier_sense, .tx_mode, .tx_bit_valid, .radio_bit_clock, .radio_data_line_oe_n, .lock_status_n, .data_format
);

// ===== verification/rfhp_host_model.sv
`timescale 1ns/1ps
// ==================================================
// host side of the serial port
module rfhp_host_model (
    output logic cfg_sel_n,           // select, parked high
    output logic cfg_sclk,            // serial clock, still between frames
    output logic cfg_serial_in,       // write data
    input  wire  cfg_serial_out,      // read data
    input  wire  cfg_serial_out_oe_n  // read enable
);
    initial begin
        cfg_sel_n = 1'b1;
        cfg_sclk = 1'b0;
        cfg_serial_in = 1'b0;
    end
    // one frame at 8 MHz; nbits below 16 aborts it
    task automatic frame(input logic [6:0] a, input logic wr, input logic [7:0] wd, input int nbits,
                         output logic [7:0] rd);
        logic [15:0] sh;
        sh = {a, wr, wd};
        rd = 8'h00;
        cfg_sel_n = 1'b0;
        #30;
        for (int i = 0; i < nbits; i++) begin
            cfg_serial_in = sh[15 - i];
            #62.5 cfg_sclk = 1'b1;
            // sample on rise, unknown if undriven
            if (i > 7) rd = {rd[6:0], cfg_serial_out_oe_n ? 1'bx : cfg_serial_out};
            #62.5 cfg_sclk = 1'b0;
        end
        #30 cfg_sel_n = 1'b1;
        cfg_serial_in = ~cfg_serial_in;
        #60;
    endtask
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ps
// ==================================================
// bench top
module tb;
    logic       clk = 1'b0, arst_n = 1'b0, power_down = 1'b0, synth_locked = 1'b1, carrier_sense = 1'b1;
    logic       tx_mode = 1'b0, rx_bit = 1'b0, host_drv = 1'b0, exp;
    logic [7:0] r;
    logic [6:0] a;
    wire        cfg_sel_n, cfg_sclk, cfg_serial_in, cfg_serial_out, cfg_serial_out_oe_n, tx_bit, tx_bit_valid;
    wire        radio_bit_clock, radio_data_line_out, radio_data_line_oe_n, lock_status_n;
    wire  [1:0] data_format;
    int         mismatches = 0, n_checks = 0, cycles = 0, mem [128], q [$];
    // shared data pin: device wins while it drives
    wire        data_pin = !radio_data_line_oe_n ? radio_data_line_out : host_drv;
    always #2 clk = ~clk;
    rfhp_host_model u_host (.cfg_sel_n, .cfg_sclk, .cfg_serial_in, .cfg_serial_out, .cfg_serial_out_oe_n);
    rfhp_port u_rfhp_port (
        .clk, .arst_n, .ce(1'b1), .cfg_sel_n, .cfg_sclk, .cfg_serial_in, .cfg_serial_out, .cfg_serial_out_oe_n,
        .power_down, .synth_locked, .carrier_sense, .tx_mode, .rx_bit, .tx_bit, .tx_bit_valid, .radio_bit_clock,
        .radio_data_line_in(data_pin), .radio_data_line_out, .radio_data_line_oe_n, .lock_status_n, .data_format
    );
    task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check1(input string what, input logic e, input logic g);
        check8(what, {7'h00, e}, {7'h00, g});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard, sized well above the planned run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            complete_run();
        end
    end
    // main sequence
    initial begin
        void'($urandom(32'he2c8a7ca));
        repeat (2) @(posedge clk);
        check8("reset enables", 8'h03, {6'h00, cfg_serial_out_oe_n, radio_data_line_oe_n});
        #1 arst_n = 1'b1;
        repeat (6) @(posedge clk);
        // 33-register configuration, scrambled address order
        for (int i = 0; i < 33; i++) begin
            a = 7'((i * 37 + 9) % 128);
            mem[a] = $urandom_range(255);
            q.push_back(a);
            u_host.frame(a, 1'b1, 8'(mem[a]), 16, r);
        end
        @(posedge clk) #1 power_down = 1'b1;
        mem[127] = 8'h5a;
        q.push_back(127);
        u_host.frame(7'h7f, 1'b1, 8'h5a, 16, r);
        u_host.frame(7'h7f, 1'b1, 8'ha5, 12, r);
        foreach (q[j]) begin
            u_host.frame(7'(q[j]), 1'b0, 8'h00, 16, r);
            check8("read back", 8'(mem[q[j]]), r);
        end
        @(posedge clk) #1 power_down = 1'b0;
        // lock pin with both selections
        for (int s = 1; s >= 0; s--) begin
            u_host.frame(7'h03, 1'b1, {5'h00, s[0], 2'h1}, 16, r);
            for (int k = 0; k < 4; k++) begin
                @(posedge clk) #1 {synth_locked, carrier_sense} = 2'(k);
                repeat (4) @(posedge clk);
                check1("lock pin", s ? !carrier_sense : !synth_locked, lock_status_n);
            end
        end
        @(posedge clk) #1 {synth_locked, carrier_sense} = 2'h3;
        check8("format", 8'h01, {6'h00, data_format});
        // receive: data launched at the fall, captured at the next rise as the host does
        for (int k = 0; k < 5; k++) begin
            @(posedge clk) #1 rx_bit = 1'($urandom);
            exp = rx_bit;
            @(negedge radio_bit_clock);
            @(posedge radio_bit_clock);
            check1("rx data", exp, data_pin);
        end
        @(posedge clk) #1;
        tx_mode = 1'b1;
        // transmit: host sets data on fall
        for (int k = 0; k < 5; k++) begin
            @(negedge radio_bit_clock);
            @(posedge clk) #1 host_drv = 1'($urandom);
            wait (tx_bit_valid === 1'b1);
            check1("tx bit", host_drv, tx_bit);
            @(posedge clk);
        end
        #1 synth_locked = 1'b0;
        repeat (20) @(posedge clk);
        check1("gated clock", 1'b0, radio_bit_clock);
        #1 synth_locked = 1'b1;
        // formats 0 and 2 keep the data port quiet
        for (int f = 0; f < 4; f += 2) begin
            u_host.frame(7'h03, 1'b1, 8'(f), 16, r);
            repeat (20) @(posedge clk);
            check8("idle port", {6'(f), 2'h1}, {data_format, radio_bit_clock, radio_data_line_oe_n});
        end
        complete_run();
    end
endmodule
